/* src/eeprom_slave.sv */
// Two-wire serial memory slave: bus protocol, address counter, page buffer and write timer
`timescale 1ns/1ns
`include "eeprom_slave_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module eeprom_slave
  import eeprom_slave_pkg::*;
#(
  // Internal write time in clock cycles, shortened in simulation
  parameter int WR_CYCLES = `WR_CYCLES_DEF,
  // Fixed device-type code; the value is arbitrary
  parameter logic [3:0] DEV_TYPE_CODE = 4'h5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus clock from the master
  input wire logic scl_i,
  // Bus data line, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Address straps and write protect
  input wire logic strap_addr_bit_lo,
  input wire logic strap_addr_bit_mid,
  input wire logic strap_addr_bit_hi,
  input wire logic wp_i,
  // Status
  output logic standby_o,
  output logic busy_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0] scl_sync_ff; // Bus clock synchroniser
  logic [1:0] sda_sync_ff; // Bus data synchroniser
  logic [1:0] wp_sync_ff; // Write-protect synchroniser
  logic [2:0] strap_sync0_ff; // Strap synchroniser, first stage
  logic [2:0] strap_sync1_ff; // Strap synchroniser, second stage
  logic scl_s; // Synchronised bus clock
  logic sda_s; // Synchronised bus data
  logic scl_prev_ff; // Bus clock one cycle back
  logic sda_prev_ff; // Bus data one cycle back
  logic scl_rise; // Bus clock rising edge
  logic scl_fall; // Bus clock falling edge
  logic start_det; // Start condition seen
  logic stop_det; // Stop condition seen

  slave_state_t state_ff; // Protocol state
  logic [`BIT_CNT_W-1:0] bit_cnt_ff; // Clock rises within the current byte
  logic [7:0] shift_ff; // Received byte
  logic [7:0] tx_ff; // Byte being sent
  logic mack_ff; // Master acknowledged the last sent byte
  logic oe_ff; // Data line pulled low
  logic [`MEM_ADDR_W-1:0] addr_ff; // Address counter
  logic [7:0] mem [`MEM_DEPTH]; // Byte array
  logic [7:0] page_buf [`PAGE_BYTES]; // Page bytes waiting for commit
  logic [`PAGE_BYTES-1:0] page_vld_ff; // Page bytes received
  logic busy_ff; // Internal write cycle running
  logic [`WR_CNT_W-1:0] wr_cnt_ff; // Internal write timer
  logic byte_done; // Eighth data bit taken, at the following fall
  logic ack_done; // Acknowledge clock finished, at the following fall
  logic dev_match; // Address byte selects this device
  logic wr_launch; // Stop launches the internal write
  logic wr_end; // Internal write finishes this cycle

  // Address byte match against type code and straps
  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] straps);
    addr_match = (b[`DEV_TYPE_HI:`DEV_TYPE_LO] == DEV_TYPE_CODE) &&
                 (b[`DEV_STRAP_HI:`DEV_STRAP_LO] == straps);
  endfunction

  // Next address within the array, rolling over to zero
  function automatic logic [`MEM_ADDR_W-1:0] addr_next(input logic [`MEM_ADDR_W-1:0] a);
    addr_next = a + `MEM_ADDR_W'(1);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  // Two flip-flops for every pin before logic reads it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      wp_sync_ff <= 2'h0;
      strap_sync0_ff <= 3'h0;
      strap_sync1_ff <= 3'h0;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
      wp_sync_ff <= {wp_sync_ff[0], wp_i};
      strap_sync0_ff <= {strap_addr_bit_hi, strap_addr_bit_mid, strap_addr_bit_lo};
      strap_sync1_ff <= strap_sync0_ff;
    end
  end

  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];

  // Previous values for edge detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
    end
  end

  // Bus events
  assign scl_rise = scl_s && !scl_prev_ff;
  assign scl_fall = !scl_s && scl_prev_ff;
  assign start_det = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
  assign stop_det = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;
  assign byte_done = scl_fall && (bit_cnt_ff == `BIT_LAST_DATA);
  assign ack_done = scl_fall && (bit_cnt_ff == `BIT_ACK_DONE);
  assign dev_match = addr_match(shift_ff, strap_sync1_ff) && !busy_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Bit counter and receive shifter

  // Data sampled on clock rise, counter cleared after the acknowledge clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_ff <= '0;
      shift_ff <= 8'h00;
      mack_ff <= 1'b0;
    end else if (start_det || stop_det) begin
      bit_cnt_ff <= '0;
    end else if (scl_rise) begin
      bit_cnt_ff <= bit_cnt_ff + `BIT_CNT_W'(1);
      if (bit_cnt_ff < `BIT_LAST_DATA) begin
        shift_ff <= {shift_ff[6:0], sda_s};
      end else begin
        mack_ff <= !sda_s;
      end
    end else if (ack_done) begin
      bit_cnt_ff <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Protocol state machine

  // Byte-level sequencing, advanced at the fall that ends each acknowledge; a foreign or busy address leaves at the eighth-bit fall
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
    end else if (start_det) begin
      state_ff <= ST_DEVADDR;
    end else if (stop_det) begin
      state_ff <= ST_IDLE;
    end else if (byte_done) begin
      case (state_ff)
        // Foreign or busy address: stay off the bus until the next start
        ST_DEVADDR: begin
          if (!dev_match) begin
            state_ff <= ST_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end else if (ack_done) begin
      case (state_ff)
        ST_DEVADDR: begin
          if (shift_ff[`DEV_DIR_BIT] == `DIR_READ) begin
            state_ff <= ST_RDATA;
          end else begin
            state_ff <= ST_ADDR_HI;
          end
        end
        ST_ADDR_HI: begin
          state_ff <= ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          state_ff <= ST_WDATA;
        end
        // Read continues only while the master acknowledges
        ST_RDATA: begin
          if (!mack_ff) begin
            state_ff <= ST_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address counter and page buffer

  // Counter loaded by the address bytes, stepped by every byte moved
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= '0;
      page_vld_ff <= '0;
    end else if (wr_end) begin
      page_vld_ff <= '0;
    end else if (byte_done) begin
      case (state_ff)
        // A new write address byte discards any earlier unsent page
        ST_DEVADDR: begin
          if (dev_match && shift_ff[`DEV_DIR_BIT] != `DIR_READ) begin
            page_vld_ff <= '0;
          end
        end
        ST_ADDR_HI: begin
          addr_ff[`MEM_ADDR_W-1:8] <= shift_ff[`ADDR_HI_USED:0];
        end
        ST_ADDR_LO: begin
          addr_ff[7:0] <= shift_ff;
        end
        ST_WDATA: begin
          page_vld_ff[addr_ff[`PAGE_OFS_W-1:0]] <= 1'b1;
          addr_ff[`PAGE_OFS_W-1:0] <= addr_ff[`PAGE_OFS_W-1:0] + `PAGE_OFS_W'(1);
        end
        default: begin
        end
      endcase
    end else if (ack_done && state_ff == ST_DEVADDR && shift_ff[`DEV_DIR_BIT] == `DIR_READ) begin
      addr_ff <= addr_next(addr_ff);
    end else if (ack_done && state_ff == ST_RDATA && mack_ff) begin
      addr_ff <= addr_next(addr_ff);
    end
  end

  // Page bytes held until the write cycle ends; later bytes overwrite earlier ones
  always_ff @(posedge clk) begin
    if (byte_done && state_ff == ST_WDATA) begin
      page_buf[addr_ff[`PAGE_OFS_W-1:0]] <= shift_ff;
    end
  end

  // Received page bytes committed in one step when the write cycle ends
  always_ff @(posedge clk) begin
    if (wr_end) begin
      for (int i = 0; i < `PAGE_BYTES; i++) begin
        if (page_vld_ff[i]) begin
          mem[{addr_ff[`MEM_ADDR_W-1:`PAGE_OFS_W], `PAGE_OFS_W'(i)}] <= page_buf[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Internal write timer

  // Stop after received data starts the cycle unless write-protected
  assign wr_launch = stop_det && state_ff == ST_WDATA && (|page_vld_ff) && !wp_sync_ff[1] &&
                     !busy_ff;
  assign wr_end = busy_ff && (wr_cnt_ff == `WR_CNT_W'(WR_CYCLES - 1));

  // Busy for exactly the write time, inputs ignored meanwhile
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_ff <= 1'b0;
      wr_cnt_ff <= '0;
    end else if (wr_launch) begin
      busy_ff <= 1'b1;
      wr_cnt_ff <= '0;
    end else if (wr_end) begin
      busy_ff <= 1'b0;
    end else if (busy_ff) begin
      wr_cnt_ff <= wr_cnt_ff + `WR_CNT_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data line driver

  // Acknowledge and read data, changed only at clock falls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oe_ff <= 1'b0;
      tx_ff <= 8'h00;
    end else if (start_det || stop_det) begin
      oe_ff <= 1'b0;
    end else if (byte_done) begin
      // Acknowledge received bytes; a sent byte leaves the line to the master
      case (state_ff)
        ST_DEVADDR: begin
          oe_ff <= dev_match;
        end
        ST_ADDR_HI, ST_ADDR_LO, ST_WDATA: begin
          oe_ff <= 1'b1;
        end
        default: begin
          oe_ff <= 1'b0;
        end
      endcase
    end else if (ack_done) begin
      // Load the byte at the counter and present its first bit
      if ((state_ff == ST_DEVADDR && shift_ff[`DEV_DIR_BIT] == `DIR_READ) ||
          (state_ff == ST_RDATA && mack_ff)) begin
        tx_ff <= mem[addr_ff];
        oe_ff <= !mem[addr_ff][7];
      end else begin
        oe_ff <= 1'b0;
      end
    end else if (scl_fall && state_ff == ST_RDATA && bit_cnt_ff < `BIT_LAST_DATA) begin
      tx_ff <= {tx_ff[6:0], 1'b0};
      oe_ff <= !tx_ff[6];
    end
  end

  // Outputs
  assign sda_o = 1'b0;
  assign sda_oe = oe_ff;
  assign busy_o = busy_ff;
  assign standby_o = (state_ff == ST_IDLE) && !busy_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_stop_idle;
    stop_det |=> state_ff == ST_IDLE && !oe_ff;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");

  property p_start_reset;
    start_det |=> state_ff == ST_DEVADDR && bit_cnt_ff == '0;
  endproperty
  a_start_reset: assert property (p_start_reset) else $error("start did not reset");

  property p_busy_silent;
    busy_ff |-> !oe_ff;
  endproperty
  a_busy_silent: assert property (p_busy_silent) else $error("drive while busy");

  property p_match_ack;
    byte_done && state_ff == ST_DEVADDR && dev_match |=> oe_ff [*2];
  endproperty
  a_match_ack: assert property (p_match_ack) else $error("address not acked");

  property p_page_wrap;
    byte_done && state_ff == ST_WDATA |=>
      addr_ff[`MEM_ADDR_W-1:`PAGE_OFS_W] == $past(addr_ff[`MEM_ADDR_W-1:`PAGE_OFS_W]) &&
      addr_ff[`PAGE_OFS_W-1:0] == $past(addr_ff[`PAGE_OFS_W-1:0]) + `PAGE_OFS_W'(1);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page wrap wrong");

  property p_wr_time;
    busy_ff |-> wr_cnt_ff < `WR_CNT_W'(WR_CYCLES);
  endproperty
  a_wr_time: assert property (p_wr_time) else $error("write cycle too long");

  property p_wp_block;
    stop_det && wp_sync_ff[1] && !busy_ff |=> !busy_ff;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("protected write ran");

  property p_standby_end;
    $fell(busy_ff) && state_ff == ST_IDLE |-> standby_o;
  endproperty
  a_standby_end: assert property (p_standby_end) else $error("no standby after write");

  property p_read_inc;
    ack_done && state_ff == ST_RDATA && mack_ff |=> addr_ff == addr_next($past(addr_ff));
  endproperty
  a_read_inc: assert property (p_read_inc) else $error("read counter not stepped");

  property p_change_low;
    $changed(oe_ff) && !$past(start_det) && !$past(stop_det) |-> !$past(scl_s);
  endproperty
  a_change_low: assert property (p_change_low) else $error("data moved with clock high");

  c_write_cycle: cover property (wr_launch ##1 busy_ff);
  c_seq_read: cover property (ack_done && state_ff == ST_RDATA && mack_ff);
  c_poll_nack: cover property (byte_done && state_ff == ST_DEVADDR && busy_ff);

endmodule

/* shared/eeprom_slave_regs.svh */
// Constants of the two-wire serial memory slave: geometry, field positions and timing
`ifndef EEPROM_SLAVE_REGS_SVH
`define EEPROM_SLAVE_REGS_SVH

// Array geometry: 8192 bytes, 32-byte pages
`define MEM_ADDR_W 13
`define MEM_DEPTH 8192
`define PAGE_OFS_W 5
`define PAGE_BYTES 32

// Slave address byte fields
`define DEV_TYPE_HI 7
`define DEV_TYPE_LO 4
`define DEV_STRAP_HI 3
`define DEV_STRAP_LO 1
`define DEV_DIR_BIT 0
`define DIR_READ 1'b1

// Memory address high byte carries only the low five bits
`define ADDR_HI_USED 4

// Bit counter values: eight data clocks, then the acknowledge clock
`define BIT_CNT_W 4
`define BIT_LAST_DATA 4'h8
`define BIT_ACK_DONE 4'h9

// Internal write cycle: longest time in ms, clock rate in MHz
`define WR_TIME_MS 5
`define CLK_MHZ 250
`define WR_CYCLES_DEF (`WR_TIME_MS * 1000 * `CLK_MHZ)
`define WR_CNT_W 21

`endif

/* shared/eeprom_slave_pkg.sv */
// Types shared by the two-wire serial memory slave
package eeprom_slave_pkg;

  // Protocol states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_DEVADDR = 7'h02,
    ST_ADDR_HI = 7'h04,
    ST_ADDR_LO = 7'h08,
    ST_WDATA   = 7'h10,
    ST_RDATA   = 7'h20,
    ST_IGNORE  = 7'h40
  } slave_state_t;

endpackage

/* tb/bus_master.sv */
// Bus master model: drives the clock and pulls the data line
`timescale 1ns/1ns
module bus_master (
  // System clock and wire level
  input wire logic clk,
  input wire logic sda,
  // Bus clock and data pull-down
  output logic scl,
  output logic pull_oe
);
  // Both lines idle released
  initial begin
    scl = 1'b1;
    pull_oe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wait n system clocks
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One bit: data moves while the clock is low, sampled mid high
  task automatic bit_xfer(input logic b, output logic r);
    scl <= 1'b0;
    wt(10);
    pull_oe <= ~b;
    wt(10);
    scl <= 1'b1;
    wt(10);
    r = sda;
    wt(10);
  endtask

  // Start: data falls while the clock is high
  task automatic start_cond();
    scl <= 1'b0;
    wt(10);
    pull_oe <= 1'b0;
    wt(10);
    scl <= 1'b1;
    wt(20);
    pull_oe <= 1'b1;
    wt(20);
  endtask

  // Stop: data rises while the clock is high, closing the operation
  task automatic stop_cond();
    scl <= 1'b0;
    wt(10);
    pull_oe <= 1'b1;
    wt(10);
    scl <= 1'b1;
    wt(20);
    pull_oe <= 1'b0;
    wt(20);
  endtask

  // Send a byte MSB first and return the slave acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  // Receive a byte, then acknowledge it or leave the line high
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~ack, r);
  endtask

  // Nine clocks with data released free a slave stuck mid byte
  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) begin
      bit_xfer(1'b1, r);
    end
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench of the two-wire serial memory slave
`timescale 1ns/1ns
module tb;
  // Short write time; device type code value is arbitrary
  localparam int WR_T = 600;
  localparam logic [3:0] TYPE_CODE = 4'h5;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] ADR_W = {TYPE_CODE, STRAP, 1'b0};
  localparam logic [7:0] ADR_R = {TYPE_CODE, STRAP, 1'b1};
  // Clock, reset and pins
  logic clk;
  logic nrst;
  logic scl;
  logic m_oe;
  logic sda_oe;
  logic wp;
  logic standby;
  logic busy;
  logic sda_dout;
  logic [2:0] straps;
  // Open-drain wire with pull-up; the slave pulls it to its drive level
  wire logic sda = ~((sda_oe & ~sda_dout) | m_oe);
  // Counters and scratch
  int num_errors;
  int num_checks;
  int cycles;
  logic ack;
  logic [7:0] rd;

  eeprom_slave #(.WR_CYCLES(WR_T), .DEV_TYPE_CODE(TYPE_CODE)) uut (
    .clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_dout), .sda_oe(sda_oe),
    .strap_addr_bit_lo(straps[0]), .strap_addr_bit_mid(straps[1]),
    .strap_addr_bit_hi(straps[2]), .wp_i(wp), .standby_o(standby), .busy_o(busy));
  bus_master master (.clk(clk), .sda(sda), .scl(scl), .pull_oe(m_oe));

  // 250 MHz clock
  always #2 clk = ~clk;

  // Cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare seen against expected
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Send a byte and compare the acknowledge
  task automatic put(input logic [7:0] d, input logic exp_ack);
    master.send_byte(d, ack);
    check(ack, exp_ack);
  endtask

  // Start, write address, two memory address bytes
  task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
    master.start_cond();
    put(ADR_W, 1'b1);
    put(hi, 1'b1);
    put(lo, 1'b1);
  endtask

  // Write n bytes from d0 upward in steps of 11h, then stop
  task automatic page_write(input logic [7:0] hi, input logic [7:0] lo,
                            input logic [7:0] d0, input int n);
    set_addr(hi, lo);
    for (int i = 0; i < n; i++) begin
      put(d0 + 8'(i * 17), 1'b1);
    end
    master.stop_cond();
  endtask

  // Poll with write addresses until the write cycle ends
  task automatic wait_done();
    master.start_cond();
    put(ADR_W, 1'b0);
    master.stop_cond();
    for (int i = 0; i < 8; i++) begin
      master.start_cond();
      master.send_byte(ADR_W, ack);
      if (ack === 1'b1)
        break;
      master.stop_cond();
    end
    check(ack, 1'b1);
    check(busy, 1'b0);
    master.stop_cond();
    check(standby, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Wrong type code or straps, both directions: silent
  task automatic t_bad_addr();
    for (int k = 0; k < 4; k++) begin
      straps <= k[1] ? ~STRAP : STRAP;
      master.wt(4);
      master.start_cond();
      put(k[1] ? (ADR_W | {7'h0, k[0]}) : {~TYPE_CODE, STRAP, k[0]}, 1'b0);
      master.recv_byte(1'b0, rd);
      check(rd, 8'hff);
      master.stop_cond();
    end
    straps <= STRAP;
  endtask

  // Page write wrapping inside the page, a second page, protected write
  task automatic t_write();
    page_write(8'hff, 8'hfe, 8'h11, 4);
    check({busy, standby}, 2'b10);
    wait_done();
    page_write(8'h00, 8'h00, 8'h5a, 2);
    wait_done();
    wp <= 1'b1;
    page_write(8'h00, 8'h00, 8'h77, 1);
    check(busy, 1'b0);
    wp <= 1'b0;
  endtask

  // Overfull page rolls over inside the page; counter then follows the last byte
  task automatic t_page_roll();
    page_write(8'h01, 8'h00, 8'h00, 33);
    wait_done();
    master.start_cond();
    put(ADR_R, 1'b1);
    master.recv_byte(1'b0, rd);
    check(rd, 8'h11);
    master.stop_cond();
    set_addr(8'h01, 8'h00);
    master.start_cond();
    put(ADR_R, 1'b1);
    master.recv_byte(1'b0, rd);
    check(rd, 8'h20);
    master.stop_cond();
  endtask

  // Sequential read across the array end
  task automatic t_seq_read();
    logic [7:0] exp [4] = '{8'h11, 8'h22, 8'h5a, 8'h6b};
    set_addr(8'h1f, 8'hfe);
    master.start_cond();
    put(ADR_R, 1'b1);
    for (int i = 0; i < 4; i++) begin
      master.recv_byte(i < 3, rd);
      check(rd, exp[i]);
    end
    master.stop_cond();
  endtask

  // Address set without data, then two current address reads
  task automatic t_cur_read();
    set_addr(8'h1f, 8'he0);
    master.stop_cond();
    check({busy, standby}, 2'b01);
    for (int i = 0; i < 2; i++) begin
      master.start_cond();
      put(ADR_R, 1'b1);
      master.recv_byte(1'b0, rd);
      check(rd, 8'h33 + 8'(i * 17));
      master.stop_cond();
    end
  endtask

  // Read abandoned at the start of the first data byte, freed by clocking and a start
  task automatic t_recover();
    set_addr(8'h1f, 8'hfe);
    master.start_cond();
    put(ADR_R, 1'b1);
    master.recover();
    check(sda, 1'b1);
    master.start_cond();
    put(ADR_W, 1'b1);
    master.stop_cond();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    wp = 1'b0;
    straps = STRAP;
    num_errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check({busy, standby, sda_oe}, 3'b010);
    t_bad_addr();
    t_write();
    t_page_roll();
    t_seq_read();
    t_cur_read();
    t_recover();
    test_done();
  end
endmodule
